// >>> vic_regs.vh
// Constants for the vectored interrupt controller: register byte offsets,
// field positions, reset values and fixed source numbers.
// Assumes a 32-bit Avalon-MM slave with a 9-bit byte address.
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// Address areas, address[8:7]
`define VIC_AREA_SMR 2'h0
`define VIC_AREA_SVR 2'h1
`define VIC_AREA_CTL 2'h2

// Control area byte offsets
`define VIC_IVR 9'h100
`define VIC_FVR 9'h104
`define VIC_ISR 9'h108
`define VIC_IPR 9'h10c
`define VIC_IMR 9'h110
`define VIC_CISR 9'h114
`define VIC_IECR 9'h120
`define VIC_IDCR 9'h124
`define VIC_ICCR 9'h128
`define VIC_ISCR 9'h12c
`define VIC_EOICR 9'h130
`define VIC_SPU 9'h134
`define VIC_DCR 9'h138
`define VIC_FFER 9'h140
`define VIC_FFDR 9'h144
`define VIC_FFSR 9'h148
`define VIC_EVT_STAT 9'h150
`define VIC_EVT_MASK 9'h154

// Source mode fields
`define VIC_PRIO_MSB 2
`define VIC_TYPE_LSB 5
`define VIC_TYPE_MSB 6
`define VIC_TYPE_RST 2'h0

// Debug control bits
`define VIC_DCR_PROT 0
`define VIC_DCR_GMSK 1

// Event status bits
`define VIC_EVT_IRQ 0
`define VIC_EVT_FIQ 1
`define VIC_EVT_SPU 2
`define VIC_EVT_W 3

// Fixed source numbers
`define VIC_NSRC 32
`define VIC_SRC_FAST 0
`define VIC_SRC_SYS 1
`define VIC_SRC_PER_LO 2
`define VIC_SRC_PER_HI 15
`define VIC_SRC_EXT0 29
`define VIC_SRC_EXT1 30

`define VIC_STACK_DEPTH 8
`define VIC_STACK_FULL 4'h8

`endif

// >>> vic_src_detect.v
// One interrupt source: edge or level detection with pending latch.
// Assumes src_i is already in the mclk_i domain.
module vic_src_detect #(
    parameter [0:0] EXTERNAL = 1'b0
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire src_i,
    input wire [1:0] type_i,
    input wire set_i,
    input wire clear_i,
    output wire pending_o
);

// Internal sources have a fixed active-high polarity
wire active_pol = EXTERNAL ? type_i[1] : 1'b1;
wire active = (src_i == active_pol);
reg prev_reg;
reg edge_reg;
wire edge_hit = type_i[0] & active & (prev_reg != src_i);

always @(posedge mclk_i) begin
    if (sys_rst_i) begin
        prev_reg <= 1'b0;
        edge_reg <= 1'b0;
    end else begin
        prev_reg <= src_i;
        if (edge_hit | set_i)
            edge_reg <= 1'b1;
        else if (clear_i)
            edge_reg <= 1'b0;
    end
end

assign pending_o = type_i[0] ? edge_reg : active;

endmodule // vic_src_detect

// >>> vic_top.v
// Vectored interrupt controller: 32 sources, 8-level nested priority,
// vectors, fast forcing, protect mode and general mask.
// Assumes an Avalon-MM master on mclk_i; peripheral lines are on mclk_i,
// the three interrupt pins are asynchronous.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`include "vic_regs.vh"

module vic_top (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire [8:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    input wire fast_interrupt_input_i,
    input wire system_peripheral_group_i,
    input wire [13:0] periph_irq_i,
    input wire external_interrupt_zero_i,
    input wire external_interrupt_one_i,
    output reg normal_request_line_low_o,
    output reg fast_request_line_low_o,
    output reg evt_irq_o
);

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg [2:0] pin_meta_reg;
reg [2:0] pin_sync_reg;
always @(posedge mclk_i) begin
    if (sys_rst_i) begin
        pin_meta_reg <= 3'h0;
        pin_sync_reg <= 3'h0;
    end else begin
        pin_meta_reg <= {external_interrupt_one_i, external_interrupt_zero_i,
                         fast_interrupt_input_i};
        pin_sync_reg <= pin_meta_reg;
    end
end

wire [31:0] src_vec = {1'b0, pin_sync_reg[2], pin_sync_reg[1], 13'h0000,
                       periph_irq_i, system_peripheral_group_i,
                       pin_sync_reg[0]};

////////////////////////////////////////////////////////////////////////////
// Configuration state
reg [2:0] smr_prio [0:31];
reg [1:0] smr_type [0:31];
reg [31:0] svr [0:31];
reg [31:0] imr_reg;
reg [31:0] ffsr_reg;
reg [31:0] spu_reg;
reg [1:0] dcr_reg;
reg [`VIC_EVT_W-1:0] evt_stat_reg;
reg [`VIC_EVT_W-1:0] evt_mask_reg;
reg [2:0] stk_prio [0:7];
reg [4:0] stk_src [0:7];
reg [3:0] depth_reg;
reg rd_valid_reg;
reg irq_q_reg;
reg fiq_q_reg;

wire bus_rd = avs_read_i & ~rd_valid_reg;
wire bus_wr = avs_write_i;
wire [1:0] area = avs_address_i[8:7];
wire [4:0] idx = avs_address_i[6:2];
wire [8:0] waddr = {avs_address_i[8:2], 2'h0};
wire prot = dcr_reg[`VIC_DCR_PROT];
wire gmsk = dcr_reg[`VIC_DCR_GMSK];

// Reads answer one cycle later; writes are taken at once
assign avs_waitrequest_o = avs_read_i & ~rd_valid_reg;

////////////////////////////////////////////////////////////////////////////
// Source detectors
wire [31:0] pend;
reg [31:0] set_vec;
reg [31:0] clr_vec;
wire [31:0] type_edge;
genvar g;
generate
    for (g = 0; g < `VIC_NSRC; g = g + 1) begin : gen_src
        assign type_edge[g] = smr_type[g][0];
        vic_src_detect #(
            .EXTERNAL((g == `VIC_SRC_FAST) || (g == `VIC_SRC_EXT0) ||
                      (g == `VIC_SRC_EXT1))
        ) u_det (
            .mclk_i(mclk_i),
            .sys_rst_i(sys_rst_i),
            .src_i(src_vec[g]),
            .type_i(smr_type[g]),
            .set_i(set_vec[g]),
            .clear_i(clr_vec[g]),
            .pending_o(pend[g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Arbitration
// source 0 is always fast
wire [31:0] fast_sel = {ffsr_reg[31:1], 1'b1};
wire [31:0] cand = pend & imr_reg & ~fast_sel;
reg win_valid;
reg [2:0] win_prio;
reg [4:0] win_src;
integer k;
// highest level wins, lowest number on tie
always @* begin
    win_valid = 1'b0;
    win_prio = 3'h0;
    win_src = 5'h00;
    for (k = 1; k < `VIC_NSRC; k = k + 1) begin
        if (cand[k] && (!win_valid || smr_prio[k] > win_prio)) begin
            win_valid = 1'b1;
            win_prio = smr_prio[k];
            win_src = k[4:0];
        end
    end
end

wire [2:0] top = depth_reg[2:0] - 3'h1;
wire stk_empty = (depth_reg == 4'h0);
wire irq_raw = win_valid & (stk_empty | (win_prio > stk_prio[top]));
wire fiq_raw = |(pend & imr_reg & fast_sel);
wire irq_req = irq_raw & ~gmsk;
wire fiq_req = fiq_raw & ~gmsk;

// Vector selection: in protect mode a write to IVR acks and FVR is never acked; otherwise a read of IVR or FVR acks
wire ivr_hit = (waddr == `VIC_IVR) & (area == `VIC_AREA_CTL);
wire fvr_hit = (waddr == `VIC_FVR) & (area == `VIC_AREA_CTL);
wire ivr_ack = ivr_hit & (prot ? bus_wr : bus_rd);
wire fvr_ack = fvr_hit & bus_rd & ~prot;
wire do_push = ivr_ack & irq_raw & (depth_reg != `VIC_STACK_FULL);
wire spurious = ivr_ack & ~irq_raw;
wire do_pop = bus_wr & (waddr == `VIC_EOICR) & ~stk_empty;

always @* begin
    set_vec = 32'h00000000;
    clr_vec = 32'h00000000;
    if (bus_wr && waddr == `VIC_ISCR)
        set_vec = avs_writedata_i & type_edge;
    if (bus_wr && waddr == `VIC_ICCR)
        clr_vec = avs_writedata_i;
    if (do_push)
        clr_vec[win_src] = 1'b1;
    if (fvr_ack)
        clr_vec[`VIC_SRC_FAST] = 1'b1;
end

////////////////////////////////////////////////////////////////////////////
// Register writes and stack
integer j;
always @(posedge mclk_i) begin
    if (sys_rst_i) begin
        for (j = 0; j < `VIC_NSRC; j = j + 1) begin
            smr_prio[j] <= 3'h0;
            smr_type[j] <= `VIC_TYPE_RST;
            svr[j] <= 32'h00000000;
        end
        for (j = 0; j < `VIC_STACK_DEPTH; j = j + 1) begin
            stk_prio[j] <= 3'h0;
            stk_src[j] <= 5'h00;
        end
        imr_reg <= 32'h00000000;
        ffsr_reg <= 32'h00000000;
        spu_reg <= 32'h00000000;
        dcr_reg <= 2'h0;
        evt_mask_reg <= 3'h0;
        depth_reg <= 4'h0;
    end else begin
        if (bus_wr && area == `VIC_AREA_SMR) begin
            smr_prio[idx] <= avs_writedata_i[`VIC_PRIO_MSB:0];
            smr_type[idx] <= avs_writedata_i[`VIC_TYPE_MSB:`VIC_TYPE_LSB];
        end
        if (bus_wr && area == `VIC_AREA_SVR)
            svr[idx] <= avs_writedata_i;
        if (bus_wr && area == `VIC_AREA_CTL) begin
            case (waddr)
                `VIC_IECR: imr_reg <= imr_reg | avs_writedata_i;
                `VIC_IDCR: imr_reg <= imr_reg & ~avs_writedata_i;
                `VIC_SPU: spu_reg <= avs_writedata_i;
                `VIC_DCR: dcr_reg <= avs_writedata_i[1:0];
                `VIC_FFER: ffsr_reg <= ffsr_reg | avs_writedata_i;
                `VIC_FFDR: ffsr_reg <= ffsr_reg & ~avs_writedata_i;
                `VIC_EVT_MASK:
                    evt_mask_reg <= avs_writedata_i[`VIC_EVT_W-1:0];
                default: begin
                end
            endcase
        end
        // push on service, pop on end
        if (do_push) begin
            stk_prio[depth_reg[2:0]] <= win_prio;
            stk_src[depth_reg[2:0]] <= win_src;
            depth_reg <= depth_reg + 4'h1;
        end else if (do_pop) begin
            depth_reg <= depth_reg - 4'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Outputs and events
wire [`VIC_EVT_W-1:0] evt_set = {spurious, fiq_req & ~fiq_q_reg,
                                 irq_req & ~irq_q_reg};
wire [`VIC_EVT_W-1:0] evt_clr =
    (bus_wr && waddr == `VIC_EVT_STAT) ? avs_writedata_i[`VIC_EVT_W-1:0]
                                       : 3'h0;
always @(posedge mclk_i) begin
    if (sys_rst_i) begin
        irq_q_reg <= 1'b0;
        fiq_q_reg <= 1'b0;
        evt_stat_reg <= 3'h0;
        evt_irq_o <= 1'b0;
        normal_request_line_low_o <= 1'b1;
        fast_request_line_low_o <= 1'b1;
    end else begin
        irq_q_reg <= irq_req;
        fiq_q_reg <= fiq_req;
        // Set wins over a same-cycle clear
        evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
        evt_irq_o <= |(evt_stat_reg & evt_mask_reg);
        normal_request_line_low_o <= ~irq_req;
        fast_request_line_low_o <= ~fiq_req;
    end
end

////////////////////////////////////////////////////////////////////////////
// Read path
reg [31:0] rd_next;
always @* begin
    rd_next = 32'h00000000;
    case (area)
        `VIC_AREA_SMR: begin
            rd_next[`VIC_PRIO_MSB:0] = smr_prio[idx];
            rd_next[`VIC_TYPE_MSB:`VIC_TYPE_LSB] = smr_type[idx];
        end
        `VIC_AREA_SVR: rd_next = svr[idx];
        `VIC_AREA_CTL: begin
            case (waddr)
                `VIC_IVR: rd_next = irq_raw ? svr[win_src] : spu_reg;
                `VIC_FVR: rd_next = fiq_raw ? svr[`VIC_SRC_FAST] : spu_reg;
                `VIC_ISR: rd_next[4:0] = stk_empty ? 5'h00 : stk_src[top];
                `VIC_IPR: rd_next = pend;
                `VIC_IMR: rd_next = imr_reg;
                `VIC_CISR: rd_next[1:0] = {fiq_raw, irq_raw};
                `VIC_SPU: rd_next = spu_reg;
                `VIC_DCR: rd_next[1:0] = dcr_reg;
                `VIC_FFSR: rd_next = fast_sel;
                `VIC_EVT_STAT: rd_next[`VIC_EVT_W-1:0] = evt_stat_reg;
                `VIC_EVT_MASK: rd_next[`VIC_EVT_W-1:0] = evt_mask_reg;
                default: rd_next = 32'h00000000;
            endcase
        end
        default: rd_next = 32'h00000000;
    endcase
end

always @(posedge mclk_i) begin
    if (sys_rst_i) begin
        rd_valid_reg <= 1'b0;
        avs_readdata_o <= 32'h00000000;
    end else begin
        rd_valid_reg <= bus_rd;
        if (bus_rd)
            avs_readdata_o <= rd_next;
    end
end

endmodule // vic_top

// >>> vic_top_checker.sv
// Port checker for the vectored interrupt controller.
// Assumes it is bound into vic_top and sees only its ports.
`include "vic_regs.vh"
module vic_top_checker (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire [8:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire normal_request_line_low_o,
    input wire fast_request_line_low_o,
    input wire evt_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////
    // Shadows of mask writes; aligned addresses only
    reg [31:0] imr_reg;
    reg gm_reg;
    reg evm_reg;
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            imr_reg <= 32'h0;
            gm_reg <= 1'b0;
            evm_reg <= 1'b0;
        end else if (avs_write_i) begin
            if (avs_address_i == `VIC_IECR)
                imr_reg <= imr_reg | avs_writedata_i;
            if (avs_address_i == `VIC_IDCR)
                imr_reg <= imr_reg & ~avs_writedata_i;
            if (avs_address_i == `VIC_DCR)
                gm_reg <= avs_writedata_i[`VIC_DCR_GMSK];
            if (avs_address_i == `VIC_EVT_MASK)
                evm_reg <= |avs_writedata_i[2:0];
        end
    end
    ////////////////////////////////////////
    wr_nowait_a: assert property (
        avs_write_i |-> !avs_waitrequest_o) else $error("write stalled");
    rd_one_wait_a: assert property (
        $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read wait not one cycle");
    rdata_hold_a: assert property (
        !$past(avs_read_i) |-> $stable(avs_readdata_o))
        else $error("read data moved without read");
    rst_lines_a: assert property (
        $fell(sys_rst_i) |-> normal_request_line_low_o
        && fast_request_line_low_o && !evt_irq_o) else $error("bad reset");
    gmask_lines_a: assert property (
        gm_reg && $past(gm_reg) |-> normal_request_line_low_o
        && fast_request_line_low_o) else $error("line through mask");
    mask_lines_a: assert property (
        imr_reg == 0 && $past(imr_reg) == 0 |-> normal_request_line_low_o
        && fast_request_line_low_o) else $error("masked line low");
    normal_src_a: assert property (
        !normal_request_line_low_o |-> $past(imr_reg[31:1]) != 0)
        else $error("normal line without mask");
    evt_quiet_a: assert property (
        !evm_reg && !$past(evm_reg) |-> !evt_irq_o)
        else $error("event output while masked");
endmodule // vic_top_checker
bind vic_top vic_top_checker u_chk (.mclk_i, .sys_rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .normal_request_line_low_o,
    .fast_request_line_low_o, .evt_irq_o);

// >>> vic_cpu_model.sv
// Core model: samples both active-low request lines as a core would.
// Assumes the lines are registered on mclk_i.
module vic_cpu_model (
    input wire mclk_i,
    input wire normal_request_line_low_i,
    input wire fast_request_line_low_i,
    output reg irq_seen_o,
    output reg fiq_seen_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge mclk_i) begin
        irq_seen_o <= ~normal_request_line_low_i;
        fiq_seen_o <= ~fast_request_line_low_i;
    end
endmodule // vic_cpu_model

// >>> test_vectored_priority_interrupt_controller.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes vic_top, its checker and vic_cpu_model are compiled first.
`include "vic_regs.vh"
module test_vectored_priority_interrupt_controller;
    timeunit 1ns;
    timeprecision 1ns;
    reg mclk_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg [8:0] adr = 9'h0;
    reg rd_r = 1'b0;
    reg we = 1'b0;
    reg [31:0] wd = 32'h0;
    reg [31:0] q;
    reg fin = 1'b0;
    reg sg = 1'b0;
    reg e0 = 1'b0;
    reg e1 = 1'b0;
    reg [13:0] pi = 14'h0;
    reg [72:0] rows [0:7];
    wire [31:0] rdata;
    wire wt;
    wire nl;
    wire fl;
    wire evt;
    wire irq;
    wire fast_interrupt_input;
    integer n_errors = 0;
    integer n_tests = 0;
    integer i;
    always #5 mclk_i = ~mclk_i;
    vic_top dut (.mclk_i, .sys_rst_i, .avs_address_i(adr),
        .avs_read_i(rd_r), .avs_write_i(we), .avs_writedata_i(wd),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
        .fast_interrupt_input_i(fin), .system_peripheral_group_i(sg),
        .periph_irq_i(pi), .external_interrupt_zero_i(e0),
        .external_interrupt_one_i(e1), .normal_request_line_low_o(nl),
        .fast_request_line_low_o(fl), .evt_irq_o(evt));
    vic_cpu_model core (.mclk_i, .normal_request_line_low_i(nl),
        .fast_request_line_low_i(fl), .irq_seen_o(irq), .fiq_seen_o(fast_interrupt_input));
    ////////////////////////////////////////
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Holds the request until waitrequest is seen low, then idles a cycle
    task bus(input r, input [8:0] a, input [31:0] d);
        integer k;
        k = 0;
        adr <= a;
        wd <= d;
        rd_r <= r;
        we <= !r;
        @(posedge mclk_i);
        while (wt !== 1'b0 && k < 20) begin
            @(posedge mclk_i);
            k = k + 1;
        end
        q = rdata;
        rd_r <= 1'b0;
        we <= 1'b0;
        if (wt !== 1'b0) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
        @(posedge mclk_i);
    endtask
    ////////////////////////////////////////
    initial begin
        rows[0] = {9'h088, 32'hcafe0002, 32'hcafe0002};
        rows[1] = {9'h0bc, 32'hcafe000f, 32'hcafe000f};
        rows[2] = {9'h0f8, 32'hcafe001e, 32'hcafe001e};
        rows[3] = {`VIC_SPU, 32'h5a5a0000, 32'h5a5a0000};
        rows[4] = {9'h008, 32'h3, 32'h3};
        rows[5] = {9'h03c, 32'h6, 32'h6};
        rows[6] = {9'h1fc, 32'hffffffff, 32'h0};
        rows[7] = {`VIC_FFSR, 32'hffffffff, 32'h1};
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        for (i = 0; i < 8; i = i + 1) begin
            bus(0, rows[i][72:64], rows[i][63:32]);
            bus(1, rows[i][72:64], 32'h0);
            chk(q, rows[i][31:0]);
        end
        // Source numbering; external pin at reset type is low level
        sg <= 1'b1;
        pi <= 14'h2000;
        repeat (2) @(posedge mclk_i);
        bus(1, `VIC_IPR, 32'h0);
        chk(q & 32'h20008000, 32'h20008000);
        chk(q & 32'h2, 32'h2);
        e0 <= 1'b1;
        repeat (4) @(posedge mclk_i);
        bus(1, `VIC_IPR, 32'h0);
        chk(q & 32'h20000000, 32'h0);
        sg <= 1'b0;
        pi <= 14'h1;
        repeat (5) @(posedge mclk_i);
        chk(irq, 1'b0);
        bus(0, `VIC_IECR, 32'h8004);
        repeat (5) @(posedge mclk_i);
        chk(irq, 1'b1);
        bus(1, `VIC_IVR, 32'h0);
        chk(q, 32'hcafe0002);
        repeat (5) @(posedge mclk_i);
        chk(irq, 1'b0);
        pi <= 14'h2001;
        repeat (5) @(posedge mclk_i);
        chk(irq, 1'b1);
        bus(1, `VIC_IVR, 32'h0);
        chk(q, 32'hcafe000f);
        bus(1, `VIC_ISR, 32'h0);
        chk(q, 32'hf);
        bus(0, `VIC_EOICR, 32'h0);
        bus(0, `VIC_EOICR, 32'h0);
        pi <= 14'h1;
        // General mask, then protect mode
        bus(0, `VIC_DCR, 32'h2);
        repeat (5) @(posedge mclk_i);
        chk(irq, 1'b0);
        bus(1, `VIC_CISR, 32'h0);
        chk(q & 32'h1, 32'h1);
        bus(0, `VIC_DCR, 32'h1);
        bus(1, `VIC_IVR, 32'h0);
        chk(q, 32'hcafe0002);
        bus(1, `VIC_ISR, 32'h0);
        chk(q, 32'h0);
        bus(0, `VIC_IVR, 32'h0);
        bus(1, `VIC_ISR, 32'h0);
        chk(q, 32'h2);
        bus(0, `VIC_EOICR, 32'h0);
        bus(0, `VIC_DCR, 32'h0);
        bus(0, `VIC_FFER, 32'h4);
        repeat (5) @(posedge mclk_i);
        chk(fast_interrupt_input, 1'b1);
        bus(0, `VIC_FFDR, 32'h4);
        bus(0, `VIC_IDCR, 32'hffffffff);
        pi <= 14'h0;
        // Rising edge latch on the second external pin
        bus(0, 9'h078, 32'h65);
        bus(0, `VIC_ICCR, 32'h40000000);
        e1 <= 1'b1;
        repeat (4) @(posedge mclk_i);
        e1 <= 1'b0;
        repeat (4) @(posedge mclk_i);
        bus(1, `VIC_IPR, 32'h0);
        chk(q & 32'h40000000, 32'h40000000);
        bus(0, `VIC_ICCR, 32'h40000000);
        bus(1, `VIC_IPR, 32'h0);
        chk(q & 32'h40000000, 32'h0);
        // Internal edge, software set, falling pin edge, spurious read
        bus(0, 9'h00c, 32'h24);
        bus(0, `VIC_ISCR, 32'h8);
        bus(1, `VIC_IPR, 32'h0);
        chk(q & 32'h8, 32'h8);
        bus(0, `VIC_ICCR, 32'h8);
        pi <= 14'h2;
        @(posedge mclk_i);
        pi <= 14'h0;
        bus(0, 9'h074, 32'h20);
        e0 <= 1'b0;
        repeat (4) @(posedge mclk_i);
        e0 <= 1'b1;
        repeat (4) @(posedge mclk_i);
        bus(1, `VIC_IPR, 32'h0);
        chk(q & 32'h8, 32'h8);
        chk(q & 32'h20000000, 32'h20000000);
        bus(1, `VIC_IVR, 32'h0);
        chk(q, 32'h5a5a0000);
        bus(1, `VIC_EVT_STAT, 32'h0);
        chk(q & 32'h4, 32'h4);
        bus(0, `VIC_ICCR, 32'h20000008);
        // Fast pin and its sticky event
        bus(0, `VIC_EVT_MASK, 32'h2);
        bus(0, 9'h000, 32'h40);
        bus(0, `VIC_IECR, 32'h1);
        fin <= 1'b1;
        repeat (6) @(posedge mclk_i);
        chk(fast_interrupt_input, 1'b1);
        chk(irq, 1'b0);
        chk(evt, 1'b1);
        bus(1, `VIC_FVR, 32'h0);
        chk(q, 32'h0);
        fin <= 1'b0;
        bus(0, `VIC_IDCR, 32'h1);
        bus(0, `VIC_EVT_STAT, 32'h2);
        repeat (2) @(posedge mclk_i);
        chk(evt, 1'b0);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        bus(1, 9'h088, 32'h0);
        chk(q, 32'h0);
        print_verdict;
    end
endmodule // test_vectored_priority_interrupt_controller
